/* File: inc/ims_pkg.sv */
/*
  Constants, register map and state types for the I2C master/slave controller.
  Assumes one 200 MHz system clock and a plain register port with 8-bit data.
*/
`default_nettype none
package ims_pkg;
  localparam int AW = 8;
  localparam int DW = 8;
  localparam int MAW = 24;
  localparam int CLK_MHZ = 200;
  localparam int MIN_CLK_PER_BIT = 10;

  localparam logic [7:0] A_DIV = 8'h00;
  localparam logic [7:0] A_ID = 8'h01;
  localparam logic [7:0] A_STAT = 8'h02;
  localparam logic [7:0] A_MODE = 8'h03;
  localparam logic [7:0] A_BUF1 = 8'h04;
  localparam logic [7:0] A_BUF2 = 8'h05;
  localparam logic [7:0] A_BUF3 = 8'h06;
  localparam logic [7:0] A_LAUNCH = 8'h07;
  localparam logic [7:0] A_LAST = 8'hE0;
  localparam logic [7:0] A_MLO = 8'hE1;
  localparam logic [7:0] A_MMID = 8'hE2;
  localparam logic [7:0] A_MHI = 8'hE3;
  localparam logic [7:0] A_HFLAG = 8'hE4;

  localparam logic [7:0] RST_DIV = 8'h1F;
  localparam logic [7:0] RST_ID = 8'h5C;
  localparam logic [7:0] RST_MODE = 8'h01;
  localparam logic [7:0] RST_BUF1 = 8'h5A;
  localparam logic [7:0] RST_BUF2 = 8'hF1;
  localparam logic [7:0] RST_BUF3 = 8'h00;
  localparam logic [7:0] RST_LAUNCH = 8'h00;
  localparam logic [7:0] RST_MLO = 8'h80;
  localparam logic [7:0] RST_MMID = 8'hD7;
  localparam logic [7:0] RST_MHI = 8'h00;

  localparam int MODE_AUTOINC = 0;
  localparam int MODE_MASTER = 1;
  localparam int MODE_MAP = 2;
  localparam int L_ID = 0;
  localparam int L_ADDR = 1;
  localparam int L_WR = 2;
  localparam int L_RD = 3;
  localparam int L_START = 4;
  localparam int L_STOP = 5;
  localparam int L_RDID = 6;
  localparam int L_RDACK = 7;
  localparam int HF_DONE = 0;
  localparam int HF_RD = 1;
  localparam int RW_BIT = 0;

  localparam logic [23:0] MEM_OFFSET = 24'h800000;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam logic [1:0] PH_H = 2'h0;
  localparam logic [1:0] PH_M = 2'h1;
  localparam logic [1:0] PH_L = 2'h2;
  localparam logic [1:0] PH_DATA = 2'h3;
  localparam logic [1:0] Q_SET = 2'h0;
  localparam logic [1:0] Q_RISE = 2'h1;
  localparam logic [1:0] Q_SAMPLE = 2'h2;
  localparam logic [1:0] Q_FALL = 2'h3;

  localparam logic [2:0] STEP_START = 3'h0;
  localparam logic [2:0] STEP_ID = 3'h1;
  localparam logic [2:0] STEP_A = 3'h2;
  localparam logic [2:0] STEP_W = 3'h3;
  localparam logic [2:0] STEP_R = 3'h4;
  localparam logic [2:0] STEP_STOP = 3'h5;

  typedef enum logic [2:0] {SL_IDLE, SL_RX, SL_ACK, SL_TX, SL_TXACK, SL_IGNORE} ims_sl_st_t;
  typedef enum logic [2:0] {M_IDLE, M_NEXT, M_START, M_BYTE, M_STOP} ims_m_st_t;
endpackage
`default_nettype wire

/* File: src/ims_ctrl.sv */
/*
  I2C controller, slave by default, master on request, with its register file.
  Assumes scl_i/sda_i already synchronous to clk, a pulled-up open-drain bus
  resolved outside, and a memory port whose read data follow mem_re by one cycle.
*/
// Strobed register access was decided locally.
// Behaviour
// - Comes out of reset as slave; stays slave until master is enabled.
// - Own slave address and master target address come from identity bits 7..1.
// - Mode control bit 2 picks memory access (0) or buffer mapping (1).
// - Slave accepts transactions while master mode is off and acknowledges bytes by itself.
// - Memory access mode runs reads and writes itself; clock must be ten times bit rate.
// - Three address bytes high, middle, low are offset by 0x800000.
// - Address given is the start; mode bit 0 makes it increment per byte.
// - Mapping mode uses a 128-byte buffer at a software-set three-byte base.
// - First half takes master writes, second half supplies master reads.
// - After each stop, mapping access restarts at the start of each half.
// - Last mapped position reads in bits 6..0, updated only at stop.
// - Master operation only while mode control bit 1 is set.
// - SCL rate is system clock over four times the divider value.
// - Launch write runs only enabled cycles, always in protocol order.
// - Status bit 0 high while an element is sent, cleared after each.
// - Status bit 1 set at start, cleared after stop is sent.
// - Master loads the acknowledge seen after each byte it sends into status bit 2.
// - Three write buffer bytes are sent first, second, third.
// - Launch 0x3f writes three bytes with acknowledges between start and stop.
// - Launch 0xf9 reads one byte into the third buffer with master acknowledge.
// - Launch bits 0..7: id, address, write, read, start, stop, read id, read ack.
// - Received acknowledge status reads 0 for ack, 1 for no ack.
// - Host-done and host-read flags set by slave traffic; write 1 clears.
`default_nettype none
module ims_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ims_pkg::AW-1:0] reg_addr,
  input wire logic [ims_pkg::DW-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [ims_pkg::DW-1:0] reg_rdata,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  output logic [ims_pkg::MAW-1:0] mem_addr,
  output logic [ims_pkg::DW-1:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  input wire logic [ims_pkg::DW-1:0] mem_rdata
);
  import ims_pkg::*;

  typedef struct packed {
    logic [7:0] div;
    logic [7:0] own;
    logic [7:0] mode;
    logic [7:0] buf1;
    logic [7:0] buf2;
    logic [7:0] buf3;
    logic [7:0] launch;
    logic [6:0] lastpos;
    logic [7:0] mlo;
    logic [7:0] mmid;
    logic [7:0] mhi;
    logic [1:0] hflag;
    logic [7:0] rdata;
    ims_sl_st_t sst;
    logic [3:0] sbit;
    logic [7:0] sshift;
    logic sisaddr;
    logic srw;
    logic sacc;
    logic [1:0] sphase;
    logic [23:0] saddr;
    logic sdrv;
    logic [7:0] stx;
    logic srdpend;
    logic [5:0] wpos;
    logic [5:0] rpos;
    logic [6:0] lastacc;
    logic prev_scl;
    logic prev_sda;
    logic [23:0] maddr;
    logic [7:0] mwdata;
    logic mwe;
    logic mre;
    ims_m_st_t mst;
    logic [2:0] mstep;
    logic [1:0] mq;
    logic [3:0] mbit;
    logic [7:0] mcnt;
    logic [7:0] mshift;
    logic mrx;
    logic mscl_drv;
    logic msda_drv;
    logic busy;
    logic pbusy;
    logic nak;
  } ims_state_t;

  ims_state_t s;
  ims_state_t next_s;

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] div_m1;
  logic tick;
  logic [23:0] dma_addr;
  logic [23:0] map_base;

  function automatic logic step_en(input logic [2:0] step, input logic [7:0] l);
    logic r;
    r = 1'b0;
    unique case (step)
      STEP_START: r = l[L_START];
      STEP_ID: r = l[L_ID];
      STEP_A: r = l[L_ADDR];
      STEP_W: r = l[L_WR];
      STEP_R: r = l[L_RD];
      STEP_STOP: r = l[L_STOP];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  assign scl_rise = scl_i & ~s.prev_scl;
  assign scl_fall = ~scl_i & s.prev_scl;
  assign bus_start = s.prev_sda & ~sda_i & scl_i & s.prev_scl;
  assign bus_stop = ~s.prev_sda & sda_i & scl_i & s.prev_scl;
  assign dma_addr = MEM_OFFSET + s.saddr;
  assign map_base = {s.mhi, s.mmid, s.mlo};
  // a divider of zero would wrap to 255 and tick only every 256 cycles, so it acts as one
  assign div_m1 = (s.div == 8'h00) ? 8'h00 : s.div - 8'h01;
  assign tick = s.mcnt >= div_m1;

  always_comb begin
    logic do_rd;
    logic do_wr;
    logic master_on;
    do_rd = 1'b0;
    do_wr = 1'b0;
    master_on = s.mode[MODE_MASTER];
    next_s = s;
    next_s.mwe = 1'b0;
    next_s.mre = 1'b0;
    next_s.rdata = 8'h00;
    next_s.prev_scl = scl_i;
    next_s.prev_sda = sda_i;

    if (reg_we) begin
      unique case (reg_addr)
        A_DIV: next_s.div = reg_wdata;
        A_ID: next_s.own = reg_wdata;
        A_MODE: next_s.mode = reg_wdata;
        A_BUF1: next_s.buf1 = reg_wdata;
        A_BUF2: next_s.buf2 = reg_wdata;
        A_BUF3: next_s.buf3 = reg_wdata;
        A_LAUNCH: next_s.launch = reg_wdata;
        A_MLO: next_s.mlo = reg_wdata;
        A_MMID: next_s.mmid = reg_wdata;
        A_MHI: next_s.mhi = reg_wdata;
        A_HFLAG: next_s.hflag = s.hflag & ~reg_wdata[HF_RD:HF_DONE];
        default: ;
      endcase
    end
    if (reg_re) begin
      unique case (reg_addr)
        A_DIV: next_s.rdata = s.div;
        A_ID: next_s.rdata = s.own;
        A_STAT: next_s.rdata = {5'h00, s.nak, s.pbusy, s.busy};
        A_MODE: next_s.rdata = s.mode;
        A_BUF1: next_s.rdata = s.buf1;
        A_BUF2: next_s.rdata = s.buf2;
        A_BUF3: next_s.rdata = s.buf3;
        A_LAUNCH: next_s.rdata = s.launch;
        A_LAST: next_s.rdata = {1'b0, s.lastpos};
        A_MLO: next_s.rdata = s.mlo;
        A_MMID: next_s.rdata = s.mmid;
        A_MHI: next_s.rdata = s.mhi;
        A_HFLAG: next_s.rdata = {6'h00, s.hflag};
        default: next_s.rdata = 8'h00;
      endcase
    end

    // slave side, only while master mode is off
    if (s.srdpend && !s.mre) begin
      next_s.stx = mem_rdata;
      next_s.srdpend = 1'b0;
    end
    if (master_on) begin
      next_s.sst = SL_IDLE;
      next_s.sdrv = 1'b0;
      next_s.sacc = 1'b0;
    end else if (bus_start) begin
      next_s.sst = SL_RX;
      next_s.sbit = 4'h0;
      next_s.sisaddr = 1'b1;
      next_s.sdrv = 1'b0;
    end else if (bus_stop) begin
      // flags are set here after any clear above, so a set in the clearing cycle wins
      if (s.sacc) begin
        next_s.hflag[HF_DONE] = 1'b1;
        if (s.srw) begin
          next_s.hflag[HF_RD] = 1'b1;
        end
        if (s.mode[MODE_MAP]) begin
          next_s.lastpos = s.lastacc;
        end
      end
      next_s.sst = SL_IDLE;
      next_s.sdrv = 1'b0;
      next_s.sacc = 1'b0;
      next_s.sphase = PH_H;
      next_s.wpos = 6'h00;
      next_s.rpos = 6'h00;
    end else begin
      unique case (s.sst)
        SL_IDLE, SL_IGNORE: next_s.sdrv = 1'b0;
        SL_RX: begin
          if (scl_rise && s.sbit < BYTE_BITS) begin
            next_s.sshift = {s.sshift[6:0], sda_i};
            next_s.sbit = s.sbit + 4'h1;
          end else if (scl_fall && s.sbit == BYTE_BITS) begin
            if (s.sisaddr) begin
              if (s.sshift[7:1] == s.own[7:1]) begin
                next_s.sacc = 1'b1;
                next_s.srw = s.sshift[RW_BIT];
                next_s.sisaddr = 1'b0;
                next_s.sst = SL_ACK;
                next_s.sdrv = 1'b1;
                do_rd = s.sshift[RW_BIT];
              end else begin
                next_s.sst = SL_IGNORE;
              end
            end else begin
              next_s.sst = SL_ACK;
              next_s.sdrv = 1'b1;
              if (s.mode[MODE_MAP] || s.sphase == PH_DATA) begin
                do_wr = 1'b1;
              end else begin
                unique case (s.sphase)
                  PH_H: next_s.saddr[23:16] = s.sshift;
                  PH_M: next_s.saddr[15:8] = s.sshift;
                  default: next_s.saddr[7:0] = s.sshift;
                endcase
                next_s.sphase = s.sphase + 2'h1;
              end
            end
          end
        end
        SL_ACK: begin
          if (scl_fall) begin
            next_s.sbit = 4'h0;
            if (s.srw) begin
              next_s.sst = SL_TX;
              next_s.sdrv = ~s.stx[7];
            end else begin
              next_s.sst = SL_RX;
              next_s.sdrv = 1'b0;
            end
          end
        end
        SL_TX: begin
          if (scl_fall) begin
            if (s.sbit == LAST_TX_BIT) begin
              next_s.sdrv = 1'b0;
              next_s.sst = SL_TXACK;
            end else begin
              next_s.sbit = s.sbit + 4'h1;
              next_s.sdrv = ~s.stx[6];
              next_s.stx = {s.stx[6:0], 1'b0};
            end
          end
        end
        SL_TXACK: begin
          // no acknowledge from the master ends the read; wait for stop
          if (scl_rise) begin
            if (sda_i) begin
              next_s.sst = SL_IGNORE;
            end else begin
              do_rd = 1'b1;
            end
          end else if (scl_fall) begin
            next_s.sst = SL_TX;
            next_s.sbit = 4'h0;
            next_s.sdrv = ~s.stx[7];
          end
        end
        default: next_s.sst = SL_IDLE;
      endcase
    end

    // prefetch gives the read data two cycles; the 10x clock leaves margin
    if (do_rd) begin
      next_s.mre = 1'b1;
      next_s.srdpend = 1'b1;
      if (s.mode[MODE_MAP]) begin
        next_s.maddr = map_base + {17'h00000, 1'b1, s.rpos};
        next_s.lastacc = {1'b1, s.rpos};
        next_s.rpos = s.rpos + 6'h01;
      end else begin
        next_s.maddr = dma_addr;
        if (s.mode[MODE_AUTOINC]) begin
          next_s.saddr = s.saddr + 24'h000001;
        end
      end
    end
    if (do_wr) begin
      next_s.mwe = 1'b1;
      next_s.mwdata = s.sshift;
      if (s.mode[MODE_MAP]) begin
        next_s.maddr = map_base + {17'h00000, 1'b0, s.wpos};
        next_s.lastacc = {1'b0, s.wpos};
        next_s.wpos = s.wpos + 6'h01;
      end else begin
        next_s.maddr = dma_addr;
        if (s.mode[MODE_AUTOINC]) begin
          next_s.saddr = s.saddr + 24'h000001;
        end
      end
    end

    // master side
    if (s.mst == M_START || s.mst == M_BYTE || s.mst == M_STOP) begin
      next_s.mcnt = tick ? 8'h00 : s.mcnt + 8'h01;
    end
    unique case (s.mst)
      M_IDLE: begin
        if (reg_we && reg_addr == A_LAUNCH && master_on) begin
          next_s.mst = M_NEXT;
          next_s.mstep = STEP_START;
        end
      end
      M_NEXT: begin
        // one cycle here per step keeps busy low between elements
        if (s.mstep > STEP_STOP || !master_on) begin
          next_s.mst = M_IDLE;
        end else if (!step_en(s.mstep, s.launch)) begin
          next_s.mstep = s.mstep + 3'h1;
        end else begin
          next_s.busy = 1'b1;
          next_s.mq = Q_SET;
          next_s.mcnt = 8'h00;
          next_s.mbit = 4'h0;
          next_s.mrx = 1'b0;
          unique case (s.mstep)
            STEP_START: next_s.mst = M_START;
            STEP_STOP: next_s.mst = M_STOP;
            STEP_ID: next_s.mshift = {s.own[7:1], s.launch[L_RDID]};
            STEP_A: next_s.mshift = s.buf1;
            STEP_W: next_s.mshift = s.buf2;
            default: begin
              next_s.mshift = s.buf3;
              next_s.mrx = s.launch[L_RDID];
            end
          endcase
          if (s.mstep != STEP_START && s.mstep != STEP_STOP) begin
            next_s.mst = M_BYTE;
          end
        end
      end
      M_START: begin
        if (tick) begin
          next_s.mq = s.mq + 2'h1;
          unique case (s.mq)
            Q_SET: begin
              next_s.msda_drv = 1'b0;
              next_s.mscl_drv = 1'b0;
            end
            Q_RISE: ;
            Q_SAMPLE: next_s.msda_drv = 1'b1;
            default: begin
              next_s.mscl_drv = 1'b1;
              next_s.busy = 1'b0;
              next_s.pbusy = 1'b1;
              next_s.mstep = s.mstep + 3'h1;
              next_s.mst = M_NEXT;
            end
          endcase
        end
      end
      M_STOP: begin
        if (tick) begin
          next_s.mq = s.mq + 2'h1;
          unique case (s.mq)
            Q_SET: next_s.msda_drv = 1'b1;
            Q_RISE: next_s.mscl_drv = 1'b0;
            Q_SAMPLE: ;
            default: begin
              next_s.msda_drv = 1'b0;
              next_s.busy = 1'b0;
              next_s.pbusy = 1'b0;
              next_s.mstep = s.mstep + 3'h1;
              next_s.mst = M_NEXT;
            end
          endcase
        end
      end
      M_BYTE: begin
        if (tick) begin
          next_s.mq = s.mq + 2'h1;
          unique case (s.mq)
            Q_SET: begin
              if (s.mbit < BYTE_BITS) begin
                next_s.msda_drv = s.mrx ? 1'b0 : ~s.mshift[7];
              end else begin
                next_s.msda_drv = s.mrx & s.launch[L_RDACK];
              end
            end
            Q_RISE: next_s.mscl_drv = 1'b0;
            Q_SAMPLE: begin
              if (s.mbit < BYTE_BITS) begin
                next_s.mshift = {s.mshift[6:0], sda_i};
              end else if (!s.mrx) begin
                next_s.nak = sda_i;
              end
            end
            default: begin
              next_s.mscl_drv = 1'b1;
              next_s.mbit = s.mbit + 4'h1;
              if (s.mbit == BYTE_BITS) begin
                if (s.mrx) begin
                  next_s.buf3 = s.mshift;
                end
                next_s.busy = 1'b0;
                next_s.mstep = s.mstep + 3'h1;
                next_s.mst = M_NEXT;
              end
            end
          endcase
        end
      end
      default: next_s.mst = M_IDLE;
    endcase
    if (s.mst == M_IDLE) begin
      next_s.mscl_drv = 1'b0;
      next_s.msda_drv = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
      s.div <= RST_DIV;
      s.own <= RST_ID;
      s.mode <= RST_MODE;
      s.buf1 <= RST_BUF1;
      s.buf2 <= RST_BUF2;
      s.buf3 <= RST_BUF3;
      s.launch <= RST_LAUNCH;
      s.mlo <= RST_MLO;
      s.mmid <= RST_MMID;
      s.mhi <= RST_MHI;
      s.sst <= SL_IDLE;
      s.mst <= M_IDLE;
      s.prev_scl <= 1'b1;
      s.prev_sda <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n = ~s.mscl_drv;
  assign sda_oe_n = ~(s.msda_drv | s.sdrv);
  assign mem_addr = s.maddr;
  assign mem_wdata = s.mwdata;
  assign mem_we = s.mwe;
  assign mem_re = s.mre;
endmodule
`default_nettype wire

/* File: testbench/ims_checker.sv */
/*
  Port checker for ims_ctrl; mirrors mode, id and map base from register writes.
  Assumes it is bound to ims_ctrl and sees only its ports.
*/
`default_nettype none
module ims_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ims_pkg::AW-1:0] reg_addr,
  input wire logic [ims_pkg::DW-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [ims_pkg::DW-1:0] reg_rdata,
  input wire logic scl_i,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic [ims_pkg::MAW-1:0] mem_addr,
  input wire logic mem_we
);
  timeunit 1ns;
  timeprecision 100ps;
  import ims_pkg::*;
  logic [7:0] mode_q;
  logic [7:0] id_q;
  logic [23:0] base_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= RST_MODE;
      id_q <= RST_ID;
      base_q <= {RST_MHI, RST_MMID, RST_MLO};
    end else if (reg_we) begin
      case (reg_addr)
        A_MODE: mode_q <= reg_wdata;
        A_ID: id_q <= reg_wdata;
        A_MLO: base_q[7:0] <= reg_wdata;
        A_MMID: base_q[15:8] <= reg_wdata;
        A_MHI: base_q[23:16] <= reg_wdata;
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_launch;
    reg_we && reg_addr == A_LAUNCH && reg_wdata[L_START] && mode_q[MODE_MASTER];
  endsequence
  sequence s_start_cond;
    ##[1:1000] !sda_oe_n && scl_oe_n;
  endsequence
  chk_slave_scl_free: assert property (!mode_q[MODE_MASTER] |-> scl_oe_n)
    else $error("scl pulled in slave mode");
  chk_launch_gated: assert property (reg_we && reg_addr == A_LAUNCH && !mode_q[MODE_MASTER]
    |=> (scl_oe_n && sda_oe_n) [*8]) else $error("launch acted without master enable");
  chk_start_first: assert property (s_launch |-> scl_oe_n throughout s_start_cond)
    else $error("start condition not first");
  chk_id_readback: assert property (reg_re && reg_addr == A_ID |=> reg_rdata == id_q)
    else $error("identity read wrong");
  chk_mode_readback: assert property (reg_re && reg_addr == A_MODE |=> reg_rdata[3:0] == mode_q[3:0])
    else $error("mode read wrong");
  chk_mem_pulse: assert property (mem_we |=> !mem_we)
    else $error("memory write longer than one cycle");
  chk_ack_write: assert property (mem_we |-> !sda_oe_n)
    else $error("write without acknowledge");
  chk_dma_offset: assert property (mem_we && !mode_q[MODE_MAP] |-> mem_addr[23])
    else $error("memory address lacks offset");
  chk_map_window: assert property (mem_we && mode_q[MODE_MAP] |-> mem_addr - base_q < 24'h40)
    else $error("mapped write outside write half");
  chk_slave_sda_low: assert property ($fell(sda_oe_n) && !mode_q[MODE_MASTER] |-> !scl_i)
    else $error("slave changed sda with scl high");
endmodule
`default_nettype wire

/* File: testbench/ims_partner.sv */
/*
  I2C partner: a master steered by bench tasks, and a slave that records bytes.
  Assumes pulled-up wires, resolved here from both sides' pull-down enables.
*/
`default_nettype none
module ims_partner (
  input wire logic clk,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  output logic scl_w,
  output logic sda_w
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int QTR = 10;
  logic scl_l = 1'b0;
  logic sda_l = 1'b0;
  logic ack_drv = 1'b0;
  logic slv_en = 1'b0;
  logic ack_en = 1'b1;
  logic [7:0] sh = 8'h00;
  logic [7:0] rxq[$];
  int cnt = 10;
  // released wires float to the pull-up level, never the last driven value
  assign scl_w = scl_oe_n & !scl_l;
  assign sda_w = sda_oe_n & !sda_l & !ack_drv;
  task automatic qwait();
    repeat (QTR) @(posedge clk);
  endtask
  task automatic m_start();
    sda_l <= 1'b1;
    qwait();
    scl_l <= 1'b1;
    qwait();
  endtask
  task automatic m_bit(input logic b, output logic r);
    sda_l <= !b;
    qwait();
    scl_l <= 1'b0;
    qwait();
    r = sda_w;
    qwait();
    scl_l <= 1'b1;
    qwait();
  endtask
  task automatic m_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) m_bit(d[i], r);
    m_bit(1'b1, ack);
  endtask
  task automatic m_stop();
    sda_l <= 1'b1;
    qwait();
    scl_l <= 1'b0;
    qwait();
    sda_l <= 1'b0;
    qwait();
  endtask
  always @(negedge sda_w) begin
    if (slv_en && scl_w) cnt = 0;
  end
  always @(posedge sda_w) begin
    if (scl_w) cnt = 10;
  end
  always @(posedge scl_w) begin
    if (slv_en && cnt < 8) begin
      sh = {sh[6:0], sda_w};
      cnt++;
    end
  end
  always @(negedge scl_w) begin
    if (slv_en && cnt == 9) begin
      ack_drv <= 1'b0;
      cnt = 0;
    end else if (slv_en && cnt == 8) begin
      rxq.push_back(sh);
      ack_drv <= ack_en;
      cnt = 9;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
/*
  Self-checking bench for ims_ctrl: register tasks, memory model, bus partner.
  Assumes ims_pkg, ims_ctrl, ims_partner and ims_checker are compiled before.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ims_pkg::*;
  localparam logic [15:0] RSTV[14] = '{16'h001F, 16'h015C, 16'h0200, 16'h0301, 16'h045A, 16'h05F1, 16'h0600,
    16'h0700, 16'hE000, 16'hE180, 16'hE2D7, 16'hE300, 16'hE400, 16'h1000};
  localparam logic [7:0] RWA[8] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'hE1, 8'hE2, 8'hE3};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [7:0] mem_rdata = 8'h00;
  logic [7:0] reg_rdata, mem_wdata;
  logic [23:0] mem_addr;
  logic mem_we, mem_re, scl_oe_n, sda_oe_n, scl_w, sda_w;
  logic meas = 1'b0;
  int failures = 0;
  int checks = 0;
  logic [23:0] exp_addr[$];
  logic [7:0] exp_data[$];
  time rises[$];
  initial forever #2.5 clk = !clk;
  ims_ctrl ims_ctrl_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .scl_i(scl_w), .scl_o(), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(),
    .sda_oe_n(sda_oe_n), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
    .mem_rdata(mem_rdata));
  ims_partner ims_partner_i (.clk(clk), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .scl_w(scl_w), .sda_w(sda_w));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // memory model; sampled on the falling edge, clear of the design's updates
  always @(negedge clk) begin
    if (mem_re) mem_rdata <= mem_addr[7:0] ^ 8'h3C;
    if (mem_we) begin
      chk(24'(exp_addr.size() > 0), 24'h1);
      chk(mem_addr, exp_addr.pop_front());
      chk(24'(mem_wdata), 24'(exp_data.pop_front()));
    end
  end
  always @(posedge scl_w) begin
    if (meas) rises.push_back($time);
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 chk(24'(reg_rdata), 24'(e));
    @(posedge clk);
  endtask
  task automatic slave_xfer(input logic [7:0] q[$], input logic ack_exp);
    logic ack;
    ims_partner_i.m_start();
    foreach (q[i]) begin
      ims_partner_i.m_byte(q[i], ack);
      chk(24'(ack), 24'(!ack_exp));
    end
    ims_partner_i.m_stop();
  endtask
  task automatic master_run(input logic [7:0] launch);
    wr(A_LAUNCH, launch);
    repeat (40) @(posedge clk);
    rdchk(A_STAT, 8'h03);
    // longest launch at the slowest divider takes about 1100 cycles
    repeat (1200) @(posedge clk);
    rdchk(A_STAT, {5'h00, !ims_partner_i.ack_en, 2'h0});
  endtask
  initial begin
    logic [7:0] d, id, lo, div;
    logic [7:0] b[3];
    logic [23:0] base;
    logic [7:0] q[$];
    void'($urandom(50089));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    foreach (RSTV[i]) rdchk(RSTV[i][15:8], RSTV[i][7:0]);
    foreach (RWA[i]) begin
      d = 8'($urandom);
      wr(RWA[i], d);
      rdchk(RWA[i], d);
    end
    wr(A_STAT, 8'hFF);
    wr(A_LAST, 8'hFF);
    wr(8'h10, 8'hFF);
    wr(A_LAUNCH, 8'h31);
    rdchk(A_STAT, 8'h00);
    rdchk(A_LAST, 8'h00);
    rdchk(8'h10, 8'h00);
    $display("registers done");
    id = {7'($urandom), 1'b0};
    wr(A_ID, id);
    for (int m = 0; m < 2; m++) begin
      wr(A_MODE, 8'(m));
      lo = 8'($urandom);
      q = '{id, 8'h04, 8'h00, lo};
      for (int i = 0; i < 3; i++) begin
        d = 8'($urandom);
        q.push_back(d);
        exp_addr.push_back(24'h840000 + 24'(lo) + 24'(m * i));
        exp_data.push_back(d);
      end
      slave_xfer(q, 1'b1);
      chk(24'(exp_addr.size()), 24'h0);
    end
    rdchk(A_HFLAG, 8'h01);
    wr(A_HFLAG, 8'h03);
    rdchk(A_HFLAG, 8'h00);
    slave_xfer('{id ^ 8'h02}, 1'b0);
    $display("memory access done");
    base = 24'($urandom);
    wr(A_MLO, base[7:0]);
    wr(A_MMID, base[15:8]);
    wr(A_MHI, base[23:16]);
    wr(A_MODE, 8'h05);
    for (int t = 2; t < 4; t++) begin
      q = '{id};
      for (int i = 0; i < t; i++) begin
        d = 8'($urandom);
        q.push_back(d);
        exp_addr.push_back(base + 24'(i));
        exp_data.push_back(d);
      end
      slave_xfer(q, 1'b1);
      rdchk(A_LAST, 8'(t - 1));
    end
    $display("mapping done");
    // software splits nothing here: each launch fits the three-byte buffer
    wr(A_MODE, 8'h03);
    div = 8'h04 + 8'($urandom % 4);
    wr(A_DIV, div);
    foreach (b[i]) begin
      b[i] = 8'($urandom);
      wr(A_BUF1 + 8'(i), b[i]);
    end
    ims_partner_i.slv_en = 1'b1;
    meas = 1'b1;
    master_run(8'h3F);
    meas = 1'b0;
    chk(24'(rises[2] - rises[1]), 24'(20 * div));
    q = '{id, b[0], b[1], b[2]};
    chk(24'(ims_partner_i.rxq.size()), 24'h4);
    foreach (q[i]) chk(24'(ims_partner_i.rxq[i]), 24'(q[i]));
    rdchk(A_STAT, 8'h00);
    ims_partner_i.rxq.delete();
    ims_partner_i.ack_en = 1'b0;
    master_run(8'h31);
    chk(24'(ims_partner_i.rxq.size()), 24'h1);
    rdchk(A_STAT, 8'h04);
    $display("master done");
    end_of_test();
  end
  // the scenarios need about 11k cycles; this leaves wide margin
  initial begin
    #500000;
    failures++;
    end_of_test();
  end
endmodule
bind ims_ctrl ims_checker ims_checker_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .scl_i(scl_i), .scl_oe_n(scl_oe_n),
  .sda_oe_n(sda_oe_n), .mem_addr(mem_addr), .mem_we(mem_we));
`default_nettype wire
